// ==== rtl/dbg_cmd_pkg.sv ====
package dbg_cmd_pkg;

    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] ALL_ONES16 = 16'hFFFF;
    localparam logic [7:0] ALL_ONES8 = 8'hFF;

    localparam logic [7:0] CMD_REV = 8'h00;
    localparam logic [7:0] CMD_CNT_WR = 8'h01;
    localparam logic [7:0] CMD_STAT_RD = 8'h02;
    localparam logic [7:0] CMD_CNT_RD = 8'h03;
    localparam logic [7:0] CMD_CTL_WR = 8'h04;
    localparam logic [7:0] CMD_CTL_RD = 8'h05;
    localparam logic [7:0] CMD_PC_WR = 8'h06;
    localparam logic [7:0] CMD_PC_RD = 8'h07;
    localparam logic [7:0] CMD_REG_WR = 8'h08;
    localparam logic [7:0] CMD_REG_RD = 8'h09;
    localparam logic [7:0] CMD_PM_WR = 8'h0A;
    localparam logic [7:0] CMD_PM_RD = 8'h0B;
    localparam logic [7:0] CMD_DM_WR = 8'h0C;
    localparam logic [7:0] CMD_DM_RD = 8'h0D;
    localparam logic [7:0] CMD_CRC = 8'h0E;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXEC = 8'h12;

    // Control register fields.
    localparam int CTL_HALT = 7;
    localparam int CTL_BRKEN = 6;
    localparam int CTL_BRKPC = 3;
    localparam int CTL_BRKZRO = 2;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Peripheral control range and flash control register under read protect.
    localparam logic [3:0] PERIPH_HI = 4'hF;
    localparam logic [11:0] FLASH_CTL_ADDR = 12'hFF8;
    localparam logic [7:0] MASS_ERASE = 8'h63;

    localparam logic [15:0] REV_DEFAULT = 16'h0100;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ARG_HI = 4'h1,
        ST_ARG_LO = 4'h2,
        ST_SIZE_HI = 4'h3,
        ST_SIZE_LO = 4'h4,
        ST_DATA_IN = 4'h5,
        ST_DATA_OUT = 4'h6,
        ST_SEND_HI = 4'h7,
        ST_SEND_LO = 4'h8,
        ST_WAIT = 4'h9
    } cmd_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_strobe_t;

    typedef struct packed {
        cmd_state_t st;
        logic [7:0] cmd;
        logic [15:0] cnt;
        logic [15:0] addr;
        logic [15:0] hold;
        logic [7:0] ctl;
        logic running;
        logic halt_prev;
        logic tx_valid;
        logic [7:0] tx_data;
        logic [7:0] tx_next;
        logic mem_we;
        logic mem_re;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic [1:0] mem_space;
        logic pc_we;
        logic cpu_step;
        logic cpu_stuff;
        logic hit;
    } dbg_state_t;

endpackage

// ==== rtl/debug_command_counter.sv ====
// Behaviour
// - 16-bit counter: cycles, zero break, PC match.
// - Counts outside debug, stops on entry or FFFF.
// - Counter clears when leaving debug mode unless zero or PC break is enabled.
// - Commands reuse counter as byte count.
// - Outside debug only a command subset works.
// - Revision command returns major then minor.
// - Counter write discarded outside debug mode.
// - Status read returns status register any mode.
// - Counter read returns inverse; outside debug FFFF.
// - Under protection halt flag set, never cleared. Code does not set it; a control write only keeps it set once halted.
// - Protection disables PC, memory, step commands.
// - Protection limits register access to F00-FFF.
// - Protection allows only mass erase to flash.
// - Characters framed 8N1 by the serial front end.
// - Counter zero or PC match enters debug.
`timescale 1ns/1ps
`default_nettype none
module debug_command_counter #(
    parameter logic [15:0] REVISION = dbg_cmd_pkg::REV_DEFAULT // Arbitrary value.
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire dbg_cmd_pkg::byte_strobe_t RX,
    output dbg_cmd_pkg::byte_strobe_t TX,
    input wire logic TX_READY,
    input wire logic READ_PROTECT_OPTION,
    input wire logic CPU_BREAK,
    input wire logic [15:0] CPU_PC,
    input wire logic [7:0] DEBUG_STATUS_REG,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_RVALID,
    input wire logic [15:0] CRC_VALUE,
    input wire logic CRC_DONE,
    output logic DEBUG_HALT_FLAG,
    output logic [7:0] DEBUG_CONTROL_REG,
    output logic [15:0] DEBUG_CYCLE_COUNTER,
    output logic MEM_WE,
    output logic MEM_RE,
    output logic [1:0] MEM_SPACE,
    output logic [15:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic PC_WE,
    output logic [15:0] PC_WDATA,
    output logic CPU_STEP,
    output logic CPU_STUFF,
    output logic [7:0] CPU_OPCODE,
    output logic CRC_START
);
    dbg_cmd_pkg::dbg_state_t s;
    dbg_cmd_pkg::dbg_state_t next_s;
    logic halted;
    logic prot;
    logic allowed;
    logic blocked_prot;
    logic periph_ok;
    logic crc_go;

    assign halted = s.ctl[dbg_cmd_pkg::CTL_HALT];
    assign prot = READ_PROTECT_OPTION;
    // Register addresses are 12 bits; only the F00-FFF page survives protection.
    assign periph_ok = (s.addr[11:8] == dbg_cmd_pkg::PERIPH_HI);

    always_comb begin
        unique case (RX.data)
            dbg_cmd_pkg::CMD_PC_WR, dbg_cmd_pkg::CMD_PC_RD, dbg_cmd_pkg::CMD_PM_WR,
            dbg_cmd_pkg::CMD_PM_RD, dbg_cmd_pkg::CMD_DM_WR, dbg_cmd_pkg::CMD_DM_RD,
            dbg_cmd_pkg::CMD_STEP, dbg_cmd_pkg::CMD_STUFF, dbg_cmd_pkg::CMD_EXEC:
                blocked_prot = prot;
            default: blocked_prot = 1'b0;
        endcase
        unique case (RX.data)
            dbg_cmd_pkg::CMD_REV, dbg_cmd_pkg::CMD_STAT_RD, dbg_cmd_pkg::CMD_CTL_WR,
            dbg_cmd_pkg::CMD_CTL_RD:
                allowed = 1'b1;
            default: allowed = halted && !blocked_prot;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.mem_we = 1'b0;
        next_s.mem_re = 1'b0;
        next_s.pc_we = 1'b0;
        next_s.cpu_step = 1'b0;
        next_s.cpu_stuff = 1'b0;
        next_s.hit = 1'b0;
        crc_go = 1'b0;
        if (TX_READY && s.tx_valid) begin
            next_s.tx_valid = 1'b0;
        end
        next_s.halt_prev = halted;

        // Counter behaviour while the CPU runs.
        if (!halted && s.halt_prev) begin
            if (!s.ctl[dbg_cmd_pkg::CTL_BRKZRO] && !s.ctl[dbg_cmd_pkg::CTL_BRKPC]) begin
                next_s.cnt = dbg_cmd_pkg::CNT_ZERO;
            end
            next_s.running = 1'b1;
        end else if (halted) begin
            next_s.running = 1'b0;
        end else if (s.running) begin
            if (s.ctl[dbg_cmd_pkg::CTL_BRKZRO]) begin
                // Down-count; reaching zero halts the CPU.
                if (s.cnt == dbg_cmd_pkg::CNT_ZERO) begin
                    next_s.hit = 1'b1;
                    next_s.running = 1'b0;
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end else if (s.ctl[dbg_cmd_pkg::CTL_BRKPC]) begin
                if (CPU_PC == s.cnt) begin
                    next_s.hit = 1'b1;
                end
            end else if (s.cnt == dbg_cmd_pkg::CNT_MAX) begin
                next_s.running = 1'b0;
            end else begin
                next_s.cnt = s.cnt + 16'h0001;
            end
        end
        unique case (s.st)
            dbg_cmd_pkg::ST_IDLE: begin
                if (RX.valid) begin
                    next_s.cmd = RX.data;
                    unique case (RX.data)
                        dbg_cmd_pkg::CMD_REV: begin
                            next_s.hold = REVISION;
                            next_s.st = dbg_cmd_pkg::ST_SEND_HI;
                        end
                        dbg_cmd_pkg::CMD_STAT_RD: begin
                            next_s.tx_next = DEBUG_STATUS_REG;
                            next_s.st = dbg_cmd_pkg::ST_SEND_LO;
                        end
                        dbg_cmd_pkg::CMD_CTL_RD: begin
                            next_s.tx_next = s.ctl;
                            next_s.st = dbg_cmd_pkg::ST_SEND_LO;
                        end
                        dbg_cmd_pkg::CMD_CNT_RD: begin
                            next_s.hold = halted ? ~s.cnt : dbg_cmd_pkg::ALL_ONES16;
                            next_s.st = dbg_cmd_pkg::ST_SEND_HI;
                        end
                        dbg_cmd_pkg::CMD_PC_RD: begin
                            next_s.hold = allowed ? CPU_PC : dbg_cmd_pkg::ALL_ONES16;
                            next_s.st = dbg_cmd_pkg::ST_SEND_HI;
                        end
                        dbg_cmd_pkg::CMD_CRC: begin
                            if (halted) begin
                                crc_go = 1'b1;
                                next_s.st = dbg_cmd_pkg::ST_WAIT;
                            end else begin
                                next_s.hold = dbg_cmd_pkg::ALL_ONES16;
                                next_s.st = dbg_cmd_pkg::ST_SEND_HI;
                            end
                        end
                        dbg_cmd_pkg::CMD_STEP: begin
                            next_s.cpu_step = allowed;
                        end
                        dbg_cmd_pkg::CMD_CTL_WR, dbg_cmd_pkg::CMD_STUFF,
                        dbg_cmd_pkg::CMD_EXEC: begin
                            next_s.st = dbg_cmd_pkg::ST_ARG_LO;
                        end
                        dbg_cmd_pkg::CMD_CNT_WR, dbg_cmd_pkg::CMD_PC_WR,
                        dbg_cmd_pkg::CMD_REG_WR, dbg_cmd_pkg::CMD_REG_RD,
                        dbg_cmd_pkg::CMD_PM_WR, dbg_cmd_pkg::CMD_PM_RD,
                        dbg_cmd_pkg::CMD_DM_WR, dbg_cmd_pkg::CMD_DM_RD: begin
                            next_s.st = dbg_cmd_pkg::ST_ARG_HI;
                        end
                        default: ;
                    endcase
                end
            end
            dbg_cmd_pkg::ST_ARG_HI: begin
                if (RX.valid) begin
                    next_s.addr[15:8] = RX.data;
                    next_s.st = dbg_cmd_pkg::ST_ARG_LO;
                end
            end
            dbg_cmd_pkg::ST_ARG_LO: begin
                if (RX.valid) begin
                    next_s.addr[7:0] = RX.data;
                    next_s.st = dbg_cmd_pkg::ST_SIZE_HI;
                    unique case (s.cmd)
                        dbg_cmd_pkg::CMD_CNT_WR: begin
                            if (halted) begin
                                next_s.cnt = {s.addr[15:8], RX.data};
                            end
                            next_s.st = dbg_cmd_pkg::ST_IDLE;
                        end
                        dbg_cmd_pkg::CMD_PC_WR: begin
                            next_s.pc_we = halted && !prot;
                            next_s.st = dbg_cmd_pkg::ST_IDLE;
                        end
                        dbg_cmd_pkg::CMD_CTL_WR: begin
                            next_s.ctl = RX.data;
                            if (prot && halted) begin
                                next_s.ctl[dbg_cmd_pkg::CTL_HALT] = 1'b1;
                            end
                            next_s.st = dbg_cmd_pkg::ST_IDLE;
                        end
                        dbg_cmd_pkg::CMD_STUFF, dbg_cmd_pkg::CMD_EXEC: begin
                            // Execute forwards its first opcode byte; the rest goes
                            // through the CPU fetch path.
                            next_s.tx_next = RX.data;
                            next_s.cpu_stuff = halted && !prot;
                            next_s.st = dbg_cmd_pkg::ST_IDLE;
                        end
                        dbg_cmd_pkg::CMD_REG_WR, dbg_cmd_pkg::CMD_REG_RD: begin
                            next_s.st = dbg_cmd_pkg::ST_SIZE_LO;
                            next_s.cnt[15:8] = 8'h00;
                        end
                        default: ;
                    endcase
                end
            end
            dbg_cmd_pkg::ST_SIZE_HI: begin
                if (RX.valid) begin
                    next_s.cnt[15:8] = RX.data;
                    next_s.st = dbg_cmd_pkg::ST_SIZE_LO;
                end
            end
            dbg_cmd_pkg::ST_SIZE_LO: begin
                if (RX.valid) begin
                    next_s.cnt[7:0] = RX.data;
                    unique case (s.cmd)
                        dbg_cmd_pkg::CMD_REG_RD, dbg_cmd_pkg::CMD_PM_RD,
                        dbg_cmd_pkg::CMD_DM_RD:
                            next_s.st = dbg_cmd_pkg::ST_DATA_OUT;
                        default: next_s.st = dbg_cmd_pkg::ST_DATA_IN;
                    endcase
                end
            end
            dbg_cmd_pkg::ST_DATA_IN: begin
                if (RX.valid) begin
                    next_s.mem_addr = s.addr;
                    next_s.mem_wdata = RX.data;
                    next_s.mem_space = s.cmd[3:2];
                    next_s.mem_we = halted && (!prot || ((s.cmd == dbg_cmd_pkg::CMD_REG_WR)
                        && periph_ok && ((s.addr[11:0] != dbg_cmd_pkg::FLASH_CTL_ADDR)
                        || (RX.data == dbg_cmd_pkg::MASS_ERASE))));
                    next_s.addr = s.addr + 16'h0001;
                    // A size of zero means the full block; decrement wraps first.
                    next_s.cnt = s.cnt - 16'h0001;
                    if (next_s.cnt == dbg_cmd_pkg::CNT_ZERO) begin
                        next_s.st = dbg_cmd_pkg::ST_IDLE;
                    end
                end
            end
            dbg_cmd_pkg::ST_DATA_OUT: begin
                if (!s.tx_valid && !s.mem_re) begin
                    if (halted && (!prot || ((s.cmd == dbg_cmd_pkg::CMD_REG_RD) && periph_ok))) begin
                        next_s.mem_re = 1'b1;
                        next_s.mem_addr = s.addr;
                        next_s.mem_space = s.cmd[3:2];
                        next_s.st = dbg_cmd_pkg::ST_WAIT;
                    end else begin
                        next_s.tx_valid = 1'b1;
                        next_s.tx_data = dbg_cmd_pkg::ALL_ONES8;
                        next_s.addr = s.addr + 16'h0001;
                        next_s.cnt = s.cnt - 16'h0001;
                        if (next_s.cnt == dbg_cmd_pkg::CNT_ZERO) begin
                            next_s.st = dbg_cmd_pkg::ST_IDLE;
                        end
                    end
                end
            end
            dbg_cmd_pkg::ST_WAIT: begin
                if (s.cmd == dbg_cmd_pkg::CMD_CRC) begin
                    next_s.cnt = CRC_VALUE;
                    if (CRC_DONE) begin
                        next_s.hold = CRC_VALUE;
                        next_s.st = dbg_cmd_pkg::ST_SEND_HI;
                    end
                end else if (MEM_RVALID) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_data = MEM_RDATA;
                    next_s.addr = s.addr + 16'h0001;
                    next_s.cnt = s.cnt - 16'h0001;
                    next_s.st = (next_s.cnt == dbg_cmd_pkg::CNT_ZERO) ?
                        dbg_cmd_pkg::ST_IDLE : dbg_cmd_pkg::ST_DATA_OUT;
                end
            end
            dbg_cmd_pkg::ST_SEND_HI: begin
                if (!s.tx_valid) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_data = s.hold[15:8];
                    next_s.tx_next = s.hold[7:0];
                    next_s.st = dbg_cmd_pkg::ST_SEND_LO;
                end
            end
            dbg_cmd_pkg::ST_SEND_LO: begin
                if (!s.tx_valid) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_data = s.tx_next;
                    next_s.st = dbg_cmd_pkg::ST_IDLE;
                end
            end
            default: next_s.st = dbg_cmd_pkg::ST_IDLE;
        endcase
        if (next_s.hit || (CPU_BREAK && s.ctl[dbg_cmd_pkg::CTL_BRKEN])) begin
            next_s.ctl[dbg_cmd_pkg::CTL_HALT] = 1'b1;
            next_s.running = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign TX.valid = s.tx_valid;
    assign TX.data = s.tx_data;
    assign DEBUG_HALT_FLAG = halted;
    assign DEBUG_CONTROL_REG = s.ctl;
    assign DEBUG_CYCLE_COUNTER = s.cnt;
    assign MEM_WE = s.mem_we;
    assign MEM_RE = s.mem_re;
    assign MEM_SPACE = s.mem_space;
    assign MEM_ADDR = s.mem_addr;
    assign MEM_WDATA = s.mem_wdata;
    assign PC_WE = s.pc_we;
    assign PC_WDATA = s.addr;
    assign CPU_STEP = s.cpu_step;
    assign CPU_STUFF = s.cpu_stuff;
    assign CPU_OPCODE = s.tx_next;
    assign CRC_START = crc_go;
endmodule
`default_nettype wire

// ==== tb/debug_command_counter_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module debug_command_counter_monitor (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire dbg_cmd_pkg::byte_strobe_t TX,
    input wire logic TX_READY,
    input wire logic READ_PROTECT_OPTION,
    input wire logic [15:0] CPU_PC,
    input wire logic DEBUG_HALT_FLAG,
    input wire logic [7:0] DEBUG_CONTROL_REG,
    input wire logic [15:0] DEBUG_CYCLE_COUNTER,
    input wire logic MEM_WE,
    input wire logic MEM_RE,
    input wire logic [1:0] MEM_SPACE,
    input wire logic [15:0] MEM_ADDR,
    input wire logic [7:0] MEM_WDATA,
    input wire logic PC_WE,
    input wire logic CPU_STEP,
    input wire logic CPU_STUFF
);
    wire logic h = DEBUG_HALT_FLAG;
    wire logic z = DEBUG_CONTROL_REG[dbg_cmd_pkg::CTL_BRKZRO];
    wire logic p = DEBUG_CONTROL_REG[dbg_cmd_pkg::CTL_BRKPC];
    wire logic e = DEBUG_CONTROL_REG[dbg_cmd_pkg::CTL_BRKEN];
    wire logic [15:0] c = DEBUG_CYCLE_COUNTER;
    wire logic prot = READ_PROTECT_OPTION;
    logic counting;

    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    // Counting only begins at a real exit from debug; reset alone never arms it.
    always_ff @(posedge MCLK) begin
        if (!RST_N) counting <= 1'b0;
        else if (h) counting <= 1'b0;
        else if ($fell(h)) counting <= 1'b1;
    end

    sequence s_counting;
        counting && !h && !z && !p;
    endsequence
    sequence s_zero_armed;
        !h && e && z && c == 16'h0001;
    endsequence
    sequence s_pc_hit;
        !h && e && p && CPU_PC == c;
    endsequence

    AST_CNT_CLEAR: assert property ($fell(h) && !z && !p |=> c == 16'h0000)
        else $error("counter not cleared on debug exit");
    AST_CNT_UP: assert property (s_counting ##0 c != 16'hFFFF |=> h || c == $past(c) + 16'h0001)
        else $error("counter did not advance by one");
    AST_CNT_SAT: assert property (s_counting ##0 c == 16'hFFFF |=> h || c == 16'hFFFF)
        else $error("counter wrapped past maximum");
    AST_ZERO_BRK: assert property (s_zero_armed |-> ##[1:3] h)
        else $error("no debug entry at counter zero");
    AST_PC_BRK: assert property (s_pc_hit |-> ##[1:3] h)
        else $error("no debug entry on pc match");
    AST_PROT_HALT: assert property (prot && h |=> h)
        else $error("halt flag cleared under protection");
    AST_PROT_CPU: assert property (prot && $past(prot) |-> !PC_WE && !CPU_STEP && !CPU_STUFF
        && !(MEM_WE && MEM_SPACE != 2'h2))
        else $error("protected command took effect");
    AST_PROT_RANGE: assert property ((MEM_WE || MEM_RE) && prot |-> MEM_SPACE == 2'h2
        && MEM_ADDR[11:8] == 4'hF)
        else $error("register access outside peripheral range");
    AST_PROT_FLASH: assert property (MEM_WE && prot
        && MEM_ADDR[11:0] == dbg_cmd_pkg::FLASH_CTL_ADDR
        |-> MEM_WDATA == dbg_cmd_pkg::MASS_ERASE)
        else $error("flash control written with other value");
    AST_IDLE_QUIET: assert property (!h && !$past(h) |-> !PC_WE && !MEM_WE && !CPU_STEP
        && !CPU_STUFF)
        else $error("debug-only command acted outside debug");
    AST_TX_HOLD: assert property (TX.valid && !TX_READY |=> TX.valid && $stable(TX.data))
        else $error("reply byte changed before accept");
endmodule

bind debug_command_counter debug_command_counter_monitor i_mon (.MCLK, .RST_N, .TX, .TX_READY,
    .READ_PROTECT_OPTION, .CPU_PC, .DEBUG_HALT_FLAG, .DEBUG_CONTROL_REG, .DEBUG_CYCLE_COUNTER,
    .MEM_WE, .MEM_RE, .MEM_SPACE, .MEM_ADDR, .MEM_WDATA, .PC_WE, .CPU_STEP, .CPU_STUFF);
`default_nettype wire

// ==== tb/debug_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    input wire logic mclk,
    output var dbg_cmd_pkg::byte_strobe_t rx,
    input wire dbg_cmd_pkg::byte_strobe_t tx,
    output var logic tx_ready
);
    int stall = 0;
    int wait_c = 0;
    logic [7:0] got_q[$];

    initial begin
        rx = '0;
        tx_ready = 1'b0;
    end

    always @(posedge mclk) begin
        if (tx.valid && tx_ready) got_q.push_back(tx.data);
    end

    // A slow host keeps ready low for stall cycles, then drops it again after each byte.
    always @(negedge mclk) begin
        if (tx.valid && !tx_ready && wait_c < stall) wait_c++;
        else if (tx.valid && !tx_ready) begin
            tx_ready <= 1'b1;
            wait_c = 0;
        end
        else tx_ready <= 1'b0;
    end

    // Data is inverted once valid drops so a stale byte is never mistaken for a new one.
    task automatic send(input logic [7:0] b);
        @(negedge mclk);
        rx <= '{valid: 1'b1, data: b};
        @(negedge mclk);
        rx <= '{valid: 1'b0, data: ~b};
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    dbg_cmd_pkg::byte_strobe_t rx, tx;
    logic tx_ready, rpo = 1'b0, mem_rvalid = 1'b0, crc_done = 1'b0, halt;
    logic mem_we, mem_re, pc_we, cpu_step, cpu_stuff, crc_start, crc_seen;
    logic [15:0] cpu_pc = 16'h0000, cnt, mem_addr, we_addr;
    logic [7:0] stat = 8'h00, mem_rdata = 8'h5A, ctl, mem_wdata, we_data;
    logic [1:0] mem_space;
    int fails = 0, total_checks = 0, n_we = 0, n_cpu = 0;

    always #10 mclk = ~mclk;

    debug_command_counter i_dut (.MCLK(mclk), .RST_N(rst_n), .RX(rx), .TX(tx),
        .TX_READY(tx_ready), .READ_PROTECT_OPTION(rpo), .CPU_BREAK(1'b0), .CPU_PC(cpu_pc),
        .DEBUG_STATUS_REG(stat), .MEM_RDATA(mem_rdata), .MEM_RVALID(mem_rvalid),
        .CRC_VALUE(16'hBEEF), .CRC_DONE(crc_done), .DEBUG_HALT_FLAG(halt),
        .DEBUG_CONTROL_REG(ctl), .DEBUG_CYCLE_COUNTER(cnt), .MEM_WE(mem_we), .MEM_RE(mem_re),
        .MEM_SPACE(mem_space), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .PC_WE(pc_we),
        .PC_WDATA(), .CPU_STEP(cpu_step), .CPU_STUFF(cpu_stuff), .CPU_OPCODE(),
        .CRC_START(crc_start));
    debug_host_model i_host (.mclk(mclk), .rx(rx), .tx(tx), .tx_ready(tx_ready));

    always @(negedge mclk) begin
        mem_rvalid <= mem_re;
        crc_done <= crc_seen;
    end
    always @(posedge mclk) begin
        if (mem_we) begin
            n_we++;
            we_addr = mem_addr;
            we_data = mem_wdata;
        end
        if (pc_we || cpu_step || cpu_stuff) n_cpu++;
        crc_seen = crc_start;
    end

    task automatic summarize();
        if (fails == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic tx5(input int n, input logic [7:0] b0, b1, b2, b3, b4);
        logic [7:0] v[5];
        v = '{b0, b1, b2, b3, b4};
        for (int i = 0; i < n; i++) i_host.send(v[i]);
        tick(4);
    endtask
    task automatic get8(output logic [7:0] b);
        int n;
        n = 0;
        while (i_host.got_q.size() == 0 && n < 400) begin
            tick(1);
            n++;
        end
        if (i_host.got_q.size() == 0) begin
            fails++;
            summarize();
        end
        else b = i_host.got_q.pop_front();
    endtask
    task automatic rd(input string name, input logic [15:0] exp, input bit wide);
        logic [7:0] hi, lo;
        hi = 8'h00;
        if (wide) get8(hi);
        get8(lo);
        check(name, exp, {hi, lo});
    endtask
    task automatic wait_halt(input string name, input int lim);
        int n;
        n = 0;
        while (halt !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        check(name, 16'h0001, {15'h0000, halt});
    endtask

    task automatic t_any_mode();
        tx5(1, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00);
        check("wake_reply", 16'h0000, 16'(i_host.got_q.size()));
        tx5(1, dbg_cmd_pkg::CMD_REV, 8'h00, 8'h00, 8'h00, 8'h00);
        rd("revision", dbg_cmd_pkg::REV_DEFAULT, 1'b1);
        stat = 8'hA5;
        tx5(1, dbg_cmd_pkg::CMD_STAT_RD, 8'h00, 8'h00, 8'h00, 8'h00);
        rd("status", 16'h00A5, 1'b0);
        tx5(1, dbg_cmd_pkg::CMD_CNT_RD, 8'h00, 8'h00, 8'h00, 8'h00);
        rd("cnt_rd_out", 16'hFFFF, 1'b1);
        tx5(3, dbg_cmd_pkg::CMD_CNT_WR, 8'h12, 8'h34, 8'h00, 8'h00);
        check("cnt_wr_out", 16'h0000, cnt);
        tx5(1, dbg_cmd_pkg::CMD_STEP, 8'h00, 8'h00, 8'h00, 8'h00);
        check("step_out", 16'h0000, 16'(n_cpu));
    endtask

    task automatic t_debug_rw();
        logic [7:0] rsv[3];
        rsv = '{8'h0F, 8'h13, 8'hFF};
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h80, 8'h00, 8'h00, 8'h00);
        check("ctl_port", 16'h0080, {8'h00, ctl});
        i_host.stall = 3;
        tx5(1, dbg_cmd_pkg::CMD_CTL_RD, 8'h00, 8'h00, 8'h00, 8'h00);
        rd("ctl_rd", 16'h0080, 1'b0);
        tx5(3, dbg_cmd_pkg::CMD_CNT_WR, 8'h12, 8'h34, 8'h00, 8'h00);
        check("cnt_wr", 16'h1234, cnt);
        tx5(1, dbg_cmd_pkg::CMD_CNT_RD, 8'h00, 8'h00, 8'h00, 8'h00);
        rd("cnt_rd", 16'hEDCB, 1'b1);
        i_host.stall = 0;
        foreach (rsv[i]) begin
            tx5(1, rsv[i], 8'h00, 8'h00, 8'h00, 8'h00);
            check("rsv_state", 16'h8012, {ctl, cnt[15:8]});
        end
        check("rsv_reply", 16'h0000, 16'(i_host.got_q.size()));
    endtask

    task automatic t_count();
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h00, 8'h00, 8'h00, 8'h00);
        tick(100);
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h80, 8'h00, 8'h00, 8'h00);
        check("cnt_span", 16'h0001, {15'h0000, cnt >= 16'h0064 && cnt <= 16'h0078});
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h00, 8'h00, 8'h00, 8'h00);
        tick(65600);
        check("cnt_sat", 16'hFFFF, cnt);
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h80, 8'h00, 8'h00, 8'h00);
    endtask

    task automatic t_breaks();
        tx5(3, dbg_cmd_pkg::CMD_CNT_WR, 8'h00, 8'h05, 8'h00, 8'h00);
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h44, 8'h00, 8'h00, 8'h00);
        wait_halt("zero_brk", 40);
        cpu_pc = 16'h0100;
        tx5(3, dbg_cmd_pkg::CMD_CNT_WR, 8'h02, 8'h00, 8'h00, 8'h00);
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h48, 8'h00, 8'h00, 8'h00);
        check("pc_nomatch", 16'h0000, {15'h0000, halt});
        cpu_pc = 16'h0200;
        wait_halt("pc_brk", 10);
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h80, 8'h00, 8'h00, 8'h00);
    endtask

    task automatic t_mem_crc();
        tx5(4, dbg_cmd_pkg::CMD_REG_RD, 8'h0F, 8'h00, 8'h02, 8'h00);
        rd("reg_rd0", 16'h005A, 1'b0);
        rd("reg_rd1", 16'h005A, 1'b0);
        tx5(1, dbg_cmd_pkg::CMD_CRC, 8'h00, 8'h00, 8'h00, 8'h00);
        rd("crc", 16'hBEEF, 1'b1);
        check("crc_cnt", 16'hBEEF, cnt);
    endtask

    task automatic t_protect();
        rpo = 1'b1;
        tx5(2, dbg_cmd_pkg::CMD_CTL_WR, 8'h00, 8'h00, 8'h00, 8'h00);
        check("prot_halt", 16'h0001, {15'h0000, halt});
        tx5(1, dbg_cmd_pkg::CMD_PC_RD, 8'h00, 8'h00, 8'h00, 8'h00);
        rd("prot_pc_rd", 16'hFFFF, 1'b1);
        n_cpu = 0;
        n_we = 0;
        tx5(3, dbg_cmd_pkg::CMD_PC_WR, 8'h12, 8'h34, 8'h00, 8'h00);
        tx5(1, dbg_cmd_pkg::CMD_STEP, 8'h00, 8'h00, 8'h00, 8'h00);
        tx5(2, dbg_cmd_pkg::CMD_STUFF, 8'hAA, 8'h00, 8'h00, 8'h00);
        check("prot_cpu", 16'h0000, 16'(n_cpu));
        tx5(5, dbg_cmd_pkg::CMD_REG_WR, 8'h00, 8'h10, 8'h01, 8'h55);
        tx5(5, dbg_cmd_pkg::CMD_REG_WR, 8'h0F, 8'hF8, 8'h01, 8'h00);
        check("prot_blocked", 16'h0000, 16'(n_we));
        tx5(5, dbg_cmd_pkg::CMD_REG_WR, 8'h0F, 8'hF8, 8'h01, dbg_cmd_pkg::MASS_ERASE);
        check("prot_erase", 16'h0001, 16'(n_we));
        check("erase_addr", {4'h0, dbg_cmd_pkg::FLASH_CTL_ADDR}, {4'h0, we_addr[11:0]});
        check("erase_data", {8'h00, dbg_cmd_pkg::MASS_ERASE}, {8'h00, we_data});
        rpo = 1'b0;
    endtask

    initial begin
        tick(12);
        rst_n = 1'b1;
        t_any_mode();
        t_debug_rw();
        t_count();
        t_breaks();
        t_mem_crc();
        t_protect();
        summarize();
    end
endmodule
`default_nettype wire
